// [dv/tb_top.sv]
// Self-checking testbench of the converter result block register core.
`timescale 1ns/10ps
`include "adr_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import adr_pkg::*;
  // ============================================================
  // Signals
  logic i_ref_clk, i_rst, i_wr, i_rd, i_cpu_halted, i_start_evt, i_smp_vld;
  logic [7:0] i_addr, i_wdata, o_rdata, rb, lf;
  logic [11:0] i_smp_raw, raw;
  logic [15:0] w, fl, ce;
  logic o_start_conv, o_value_done, o_window_hit, o_halted;
  int err_total, compares, n;

  adr_top u_adr_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cpu_halted(i_cpu_halted), .i_start_evt(i_start_evt),
    .i_smp_vld(i_smp_vld), .i_smp_raw(i_smp_raw), .o_start_conv(o_start_conv),
    .o_value_done(o_value_done), .o_window_hit(o_window_hit), .o_halted(o_halted));

  initial i_ref_clk = 1'b0;
  always #20 i_ref_clk = ~i_ref_clk;

  // ============================================================
  // Expectations and random source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [15:0] clamp(input logic [11:0] r);
    if (r[11]) return 16'h0000;
    if (r[10]) return 16'h03ff;
    return {6'h00, r[9:0]};
  endfunction

  function automatic logic win_exp(input int m, input logic [15:0] v, f, c);
    case (m)
      1: return v < f;
      2: return v > c;
      3: return (f < v) && (v < c);
      4: return (v < f) || (v > c);
      default: return 1'b0;
    endcase
  endfunction

  // ============================================================
  // Bus and stimulus tasks
  task automatic idle(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    v = {hi, lo};
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic smp(input logic [11:0] r, input int k);
    @(posedge i_ref_clk);
    i_smp_vld <= 1'b1;
    i_smp_raw <= r;
    repeat (k) @(posedge i_ref_clk);
    i_smp_vld <= 1'b0;
    idle(4);
  endtask

  task automatic evt(output int c);
    c = 0;
    @(posedge i_ref_clk);
    i_start_evt <= 1'b1;
    repeat (8) begin
      @(posedge i_ref_clk);
      #1;
      if (o_start_conv === 1'b1) c++;
    end
    i_start_evt <= 1'b0;
    idle(6);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    err_total++;
    stop_test();
  end

  // ============================================================
  // Main sequence
  initial begin
    err_total = 0;
    compares = 0;
    lf = 8'h4c;
    i_rst = 1'b1;
    {i_wr, i_rd, i_cpu_halted, i_start_evt, i_smp_vld} = 5'h00;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_smp_raw = 12'h000;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(`ADR_OFF_DEBUG_CTL, rb); `CHK(rb, 8'h00)
    rd(`ADR_OFF_STAGE, rb); `CHK(rb, `ADR_RST_BYTE)
    rd16(`ADR_OFF_VALUE_LO, w); `CHK(w, `ADR_RST_WORD)
    rd16(`ADR_OFF_FLOOR_LO, w); `CHK(w, `ADR_RST_WORD)
    wr(8'h30, 8'ha5);
    rd(8'h30, rb); `CHK(rb, 8'h00)
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wr(`ADR_OFF_STAGE, lf);
      rd(`ADR_OFF_STAGE, rb); `CHK(rb, lf)
    end
    // Floor and ceiling share the staging byte; a low write alone must not commit.
    wr(`ADR_OFF_FLOOR_LO, 8'h3c);
    rd(`ADR_OFF_STAGE, rb); `CHK(rb, 8'h3c)
    wr(`ADR_OFF_FLOOR_HI, 8'h01);
    rd16(`ADR_OFF_FLOOR_LO, w); `CHK(w, 16'h013c)
    fl = 16'h0100;
    ce = 16'h0200;
    wr16(`ADR_OFF_FLOOR_LO, fl);
    wr16(`ADR_OFF_CEIL_LO, ce);
    rd16(`ADR_OFF_FLOOR_LO, w); `CHK(w, fl)
    rd16(`ADR_OFF_CEIL_LO, w); `CHK(w, ce)
    // Single samples: clamps at both ends and random codes.
    wr(`ADR_OFF_ACC_SEL, 8'h00);
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      raw = {lf[3:0], lfsr(lf)};
      if (i == 0) raw = 12'h800;
      if (i == 1) raw = 12'h7ff;
      if (i == 2) raw = 12'h3ff;
      smp(raw, 1);
      `CHK(o_value_done, 1'b1)
      rd(`ADR_OFF_VALUE_LO, rb);
      idle(1);
      `CHK(o_value_done, 1'b0)
      rd(`ADR_OFF_VALUE_HI, w[15:8]);
      `CHK({w[15:8], rb}, clamp(raw))
    end
    // Flag clears only by a one written to it, or a read of the low byte.
    smp(12'h010, 1);
    wr(`ADR_OFF_FLAGS, 8'h00);
    rd(`ADR_OFF_VALUE_HI, rb);
    idle(1); `CHK(o_value_done, 1'b1)
    rd(`ADR_OFF_FLAGS, rb); `CHK(rb, 8'h01)
    wr(`ADR_OFF_FLAGS, 8'h01);
    idle(1); `CHK(o_value_done, 1'b0)
    // Every compare select code against values below, at, inside and above.
    for (int m = 0; m < 8; m++) begin
      wr(`ADR_OFF_WIN_MODE, m[7:0]);
      rd(`ADR_OFF_WIN_MODE, rb); `CHK(rb, m[7:0])
      for (int j = 0; j < 4; j++) begin
        raw = (j == 0) ? 12'h080 : (j == 1) ? 12'h100 : (j == 2) ? 12'h180 : 12'h300;
        wr(`ADR_OFF_FLAGS, 8'h03);
        smp(raw, 1);
        `CHK(o_window_hit, win_exp(m, clamp(raw), fl, ce))
      end
    end
    // Two samples each below the floor, total above it: no hit.
    wr(`ADR_OFF_WIN_MODE, 8'h01);
    wr(`ADR_OFF_ACC_SEL, 8'h01);
    wr(`ADR_OFF_FLAGS, 8'h03);
    smp(12'h010, 1);
    `CHK(o_value_done, 1'b0)
    smp(12'h0f8, 1);
    `CHK(o_window_hit, 1'b0)
    rd16(`ADR_OFF_VALUE_LO, w); `CHK(w, 16'h0108)
    // Selector above the cap still means 64 samples of full scale.
    wr(`ADR_OFF_WIN_MODE, 8'h00);
    wr(`ADR_OFF_ACC_SEL, 8'h07);
    rd(`ADR_OFF_ACC_SEL, rb); `CHK(rb, 8'h07)
    smp(12'h7ff, 63);
    `CHK(o_value_done, 1'b0)
    smp(12'h7ff, 1);
    `CHK(o_value_done, 1'b1)
    rd16(`ADR_OFF_VALUE_LO, w); `CHK(w, `ADR_ACC_CEIL)
    // Debug halt without and with keep-running.
    wr(`ADR_OFF_ACC_SEL, 8'h00);
    wr(`ADR_OFF_FLAGS, 8'h03);
    wr(`ADR_OFF_DEBUG_CTL, 8'h00);
    i_cpu_halted <= 1'b1;
    idle(3); `CHK(o_halted, 1'b1)
    smp(12'h055, 1);
    `CHK(o_value_done, 1'b0)
    evt(n); `CHK(n, 0)
    wr(`ADR_OFF_DEBUG_CTL, 8'h01);
    idle(3); `CHK(o_halted, 1'b0)
    smp(12'h055, 1);
    `CHK(o_value_done, 1'b1)
    evt(n); `CHK(n, 1)
    i_cpu_halted <= 1'b0;
    rd(`ADR_OFF_DEBUG_CTL, rb); `CHK(rb, 8'h01)
    rd16(`ADR_OFF_VALUE_LO, w); `CHK(w, 16'h0055)
    stop_test();
  end
endmodule

// [hw/adr_accum.sv]
// Sample clamp and accumulator of the converter result block.
`timescale 1ns/10ps
`include "adr_regs.svh"
module adr_accum (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Link to the core
  adr_link_if.acc lnk
);
  import adr_pkg::*;

  adr_acc_st_t q;
  adr_acc_st_t d;
  logic [9:0] smp_c;
  logic [16:0] sum_w;
  logic [15:0] sum_c;
  logic [2:0] sel_e;
  logic [6:0] cnt_n;

  // ============================================================
  // Clamp, accumulate and cap.
  always_comb begin
    d = q;
    d.tot_vld = 1'b0;
    if (lnk.smp_raw[11]) begin
      smp_c = `ADR_SMP_MIN;
    end else if (lnk.smp_raw[10]) begin
      smp_c = `ADR_SMP_MAX;
    end else begin
      smp_c = lnk.smp_raw[9:0];
    end
    sel_e = (lnk.acc_sel > `ADR_ACC_SEL_MAX) ? `ADR_ACC_SEL_MAX : lnk.acc_sel;
    sum_w = {1'b0, q.sum} + {7'h00, smp_c};
    sum_c = (sum_w > {1'b0, `ADR_ACC_CEIL}) ? `ADR_ACC_CEIL : sum_w[15:0];
    cnt_n = q.cnt + 7'h01;
    if (lnk.smp_vld) begin
      // A count left over from a larger selector closes the total at once instead of wrapping.
      if (cnt_n >= (7'h01 << sel_e)) begin
        d.tot_vld = 1'b1;
        d.tot = sum_c;
        d.sum = `ADR_RST_WORD;
        d.cnt = 7'h00;
      end else begin
        d.sum = sum_c;
        d.cnt = cnt_n;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.tot_vld = q.tot_vld;
  assign lnk.tot = q.tot;

  a_total_ceiling: assert property (@(posedge i_ref_clk) disable iff (i_rst) q.tot <= `ADR_ACC_CEIL)
    else $error("Accumulated total above ceiling.");
  a_single_clamp: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (lnk.smp_vld && lnk.acc_sel == 3'h0 && !lnk.smp_raw[11] && lnk.smp_raw[10]) |=> q.tot == 16'h03ff)
    else $error("Over-range sample not saturated.");
  a_single_floor: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (lnk.smp_vld && lnk.acc_sel == 3'h0 && lnk.smp_raw[11]) |=> q.tot == 16'h0000)
    else $error("Negative sample not clamped to zero.");
endmodule

// [hw/adr_link_if.sv]
// Signals between the register core, the accumulator and the window comparator.
`timescale 1ns/10ps
interface adr_link_if;
  logic smp_vld;
  logic [11:0] smp_raw;
  logic [2:0] acc_sel;
  logic tot_vld;
  logic [15:0] tot;
  logic [15:0] floor_v;
  logic [15:0] ceil_v;
  logic [2:0] mode;
  logic hit;

  modport core (output smp_vld, output smp_raw, output acc_sel, output floor_v, output ceil_v, output mode,
                input tot_vld, input tot, input hit);
  modport acc (input smp_vld, input smp_raw, input acc_sel, output tot_vld, output tot);
  modport win (input tot_vld, input tot, input floor_v, input ceil_v, input mode, output hit);
endinterface

// [hw/adr_pkg.sv]
// Types shared by the converter result block.
package adr_pkg;

  // ============================================================
  // Window compare select encoding.
  typedef enum logic [2:0] {
    ADR_WM_NONE = 3'h0,
    ADR_WM_BELOW = 3'h1,
    ADR_WM_ABOVE = 3'h2,
    ADR_WM_INSIDE = 3'h3,
    ADR_WM_OUTSIDE = 3'h4
  } adr_win_mode_t;

  // ============================================================
  // State records of the three modules.
  typedef struct packed {
    logic [6:0] cnt;
    logic [15:0] sum;
    logic tot_vld;
    logic [15:0] tot;
  } adr_acc_st_t;

  typedef struct packed {
    logic hit;
  } adr_win_st_t;

  typedef struct packed {
    logic keep_run;
    logic [7:0] stage;
    logic [15:0] value;
    logic [15:0] floor_v;
    logic [15:0] ceil_v;
    logic [2:0] mode;
    logic [2:0] acc_sel;
    logic done;
    logic whit;
    logic [7:0] rdata;
    logic evt_s1;
    logic evt_s2;
    logic evt_prev;
    logic start;
    logic halted;
  } adr_top_st_t;

endpackage

// [hw/adr_regs.svh]
// Register offsets, field positions, reset values and limits of the converter result block.
`ifndef ADR_REGS_SVH
`define ADR_REGS_SVH

// ============================================================
// Register offsets
`define ADR_OFF_ACC_SEL 8'h02
`define ADR_OFF_WIN_MODE 8'h04
`define ADR_OFF_FLAGS 8'h0b
`define ADR_OFF_DEBUG_CTL 8'h0c
`define ADR_OFF_STAGE 8'h0d
`define ADR_OFF_VALUE_LO 8'h10
`define ADR_OFF_VALUE_HI 8'h11
`define ADR_OFF_FLOOR_LO 8'h12
`define ADR_OFF_FLOOR_HI 8'h13
`define ADR_OFF_CEIL_LO 8'h14
`define ADR_OFF_CEIL_HI 8'h15

// ============================================================
// Field positions
`define ADR_BIT_KEEP_RUN 0
`define ADR_BIT_DONE 0
`define ADR_BIT_WHIT 1

// ============================================================
// Reset values and limits
`define ADR_RST_BYTE 8'h00
`define ADR_RST_WORD 16'h0000
`define ADR_SMP_MAX 10'h3ff
`define ADR_SMP_MIN 10'h000
`define ADR_ACC_CEIL 16'hffc0
`define ADR_ACC_SEL_MAX 3'h6

`endif

// [hw/adr_top.sv]
// Register core of the converter result block: debug halt, byte staging, value and window floor and ceiling.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "adr_regs.svh"
module adr_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Debug and trigger
  input wire logic i_cpu_halted,
  input wire logic i_start_evt,
  // Converter core samples
  input wire logic i_smp_vld,
  input wire logic [11:0] i_smp_raw,
  // Status
  output logic o_start_conv,
  output logic o_value_done,
  output logic o_window_hit,
  output logic o_halted
);
  import adr_pkg::*;

  adr_top_st_t q;
  adr_top_st_t d;
  logic active;
  logic evt_rise;
  logic rd_value_lo;
  logic wr_flags;

  adr_link_if lnk ();

  // ============================================================
  // Submodules
  adr_accum u_accum (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .lnk(lnk.acc)
  );

  adr_window u_window (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .lnk(lnk.win)
  );

  // ============================================================
  // Run gating
  // The converter only advances while the CPU runs or software asked it to keep running.
  assign active = q.keep_run || !i_cpu_halted;
  assign evt_rise = q.evt_s2 && !q.evt_prev;

  assign lnk.smp_vld = i_smp_vld && active;
  assign lnk.smp_raw = i_smp_raw;
  assign lnk.acc_sel = q.acc_sel;
  assign lnk.floor_v = q.floor_v;
  assign lnk.ceil_v = q.ceil_v;
  assign lnk.mode = q.mode;

  assign rd_value_lo = i_rd && (i_addr == `ADR_OFF_VALUE_LO);
  assign wr_flags = i_wr && (i_addr == `ADR_OFF_FLAGS);

  // ============================================================
  // Next state
  always_comb begin
    d = q;
    d.evt_s1 = i_start_evt;
    d.evt_s2 = q.evt_s1;
    d.evt_prev = q.evt_s2;
    d.start = evt_rise && active;
    d.halted = !active;
    d.rdata = 8'h00;

    // A finished total lands in the value register for software to read.
    if (lnk.tot_vld) begin
      d.value = lnk.tot;
    end

    // Register reads; reading the low half stages the high half.
    if (i_rd) begin
      case (i_addr)
        `ADR_OFF_ACC_SEL: d.rdata = {5'h00, q.acc_sel};
        `ADR_OFF_WIN_MODE: d.rdata = {5'h00, q.mode};
        `ADR_OFF_FLAGS: d.rdata = {6'h00, q.whit, q.done};
        `ADR_OFF_DEBUG_CTL: d.rdata = {7'h00, q.keep_run};
        `ADR_OFF_STAGE: d.rdata = q.stage;
        `ADR_OFF_VALUE_LO: begin
          d.rdata = q.value[7:0];
          d.stage = q.value[15:8];
        end
        `ADR_OFF_VALUE_HI: d.rdata = q.stage;
        `ADR_OFF_FLOOR_LO: begin
          d.rdata = q.floor_v[7:0];
          d.stage = q.floor_v[15:8];
        end
        `ADR_OFF_FLOOR_HI: d.rdata = q.stage;
        `ADR_OFF_CEIL_LO: begin
          d.rdata = q.ceil_v[7:0];
          d.stage = q.ceil_v[15:8];
        end
        `ADR_OFF_CEIL_HI: d.rdata = q.stage;
        default: d.rdata = 8'h00;
      endcase
    end

    // Register writes; a low half waits in the staging byte for its high half.
    if (i_wr) begin
      case (i_addr)
        `ADR_OFF_ACC_SEL: d.acc_sel = i_wdata[2:0];
        `ADR_OFF_WIN_MODE: d.mode = i_wdata[2:0];
        `ADR_OFF_DEBUG_CTL: d.keep_run = i_wdata[`ADR_BIT_KEEP_RUN];
        `ADR_OFF_STAGE: d.stage = i_wdata;
        `ADR_OFF_FLOOR_LO: d.stage = i_wdata;
        `ADR_OFF_FLOOR_HI: d.floor_v = {i_wdata, q.stage};
        `ADR_OFF_CEIL_LO: d.stage = i_wdata;
        `ADR_OFF_CEIL_HI: d.ceil_v = {i_wdata, q.stage};
        default: d.stage = d.stage;
      endcase
    end

    // Flags clear on write-one or on a read of the low value byte; a new event wins over the clear.
    if (rd_value_lo || (wr_flags && i_wdata[`ADR_BIT_DONE])) begin
      d.done = 1'b0;
    end
    if (rd_value_lo || (wr_flags && i_wdata[`ADR_BIT_WHIT])) begin
      d.whit = 1'b0;
    end
    if (lnk.tot_vld) begin
      d.done = 1'b1;
    end
    if (lnk.hit) begin
      d.whit = 1'b1;
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // Outputs
  assign o_rdata = q.rdata;
  assign o_start_conv = q.start;
  assign o_value_done = q.done;
  assign o_window_hit = q.whit;
  assign o_halted = q.halted;

  // ============================================================
  // Checks
  a_halt_blocks_event: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_cpu_halted && !q.keep_run) |=> (!q.start && q.halted))
    else $error("Start issued while halted without keep-running.");

  a_halt_blocks_sample: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_cpu_halted && !q.keep_run) |-> !lnk.smp_vld)
    else $error("Sample accepted while halted.");

  a_keep_run_event: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (q.keep_run && q.evt_s2 && !q.evt_prev) |=> q.start)
    else $error("Event lost while keep-running set.");

  a_stage_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_STAGE) ##1 (i_rd && i_addr == `ADR_OFF_STAGE) |=> o_rdata == $past(i_wdata, 2))
    else $error("Staging byte does not read back.");

  a_low_read_stages: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    rd_value_lo |=> (q.stage == $past(q.value[15:8]) && o_rdata == $past(q.value[7:0])))
    else $error("Low read did not stage the high byte.");

  a_high_read_pair: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_VALUE_HI) |=> o_rdata == $past(q.stage))
    else $error("High byte read not served from staging.");

  a_floor_commit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_FLOOR_HI) |=> q.floor_v == {$past(i_wdata), $past(q.stage)})
    else $error("Floor not committed as one word.");

  a_floor_low_held: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_FLOOR_LO) |=> $stable(q.floor_v))
    else $error("Floor changed on low byte write.");

  a_done_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    lnk.tot_vld |=> (q.done && q.value == $past(lnk.tot)))
    else $error("Finished total not flagged.");

  a_done_clear_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wr_flags && i_wdata[0] && !lnk.tot_vld) |=> !q.done)
    else $error("Write-one did not clear the done flag.");

  a_done_write_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wr_flags && !i_wdata[0] && !rd_value_lo && q.done) |=> q.done)
    else $error("Write-zero changed the done flag.");

  a_value_ceiling: assert property (@(posedge i_ref_clk) disable iff (i_rst) q.value <= `ADR_ACC_CEIL)
    else $error("Conversion value above ceiling.");

  a_stage_read_back: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_STAGE) |=> o_rdata == $past(q.stage))
    else $error("Staging byte read returned a wrong value.");

  a_stage_direct: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_STAGE) |=> q.stage == $past(i_wdata))
    else $error("Staging byte write not taken.");

  a_floor_low_stages: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_FLOOR_LO) |=> q.stage == $past(i_wdata))
    else $error("Floor low byte not held in staging.");

  a_floor_read_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_FLOOR_LO) |=> (o_rdata == $past(q.floor_v[7:0]) && q.stage == $past(q.floor_v[15:8])))
    else $error("Floor low read did not stage the high byte.");

  a_floor_read_high: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_FLOOR_HI) |=> o_rdata == $past(q.stage))
    else $error("Floor high read not served from staging.");

  a_floor_only_commit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(i_wr && i_addr == `ADR_OFF_FLOOR_HI) |=> $stable(q.floor_v))
    else $error("Floor changed without a high byte write.");

  a_ceil_shares_stage: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_CEIL_LO) |=> q.stage == $past(i_wdata))
    else $error("Ceiling low byte not held in the shared staging byte.");

  a_value_only_total: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !lnk.tot_vld |=> $stable(q.value))
    else $error("Conversion value changed without a finished total.");

  a_value_read_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rd_value_lo && !lnk.tot_vld) |=> !q.done)
    else $error("Value read did not clear the done flag.");

  a_hit_read_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (rd_value_lo && !lnk.hit) |=> !q.whit)
    else $error("Value read did not clear the window flag.");

  a_hit_clear_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wr_flags && i_wdata[`ADR_BIT_WHIT] && !lnk.hit) |=> !q.whit)
    else $error("Write-one did not clear the window flag.");

  a_hit_write_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wr_flags && !i_wdata[`ADR_BIT_WHIT] && !rd_value_lo && q.whit) |=> q.whit)
    else $error("Write-zero changed the window flag.");

  a_hit_sets_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    lnk.hit |=> q.whit)
    else $error("Window hit not flagged.");

  a_done_needs_total: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!lnk.tot_vld && !q.done) |=> !q.done)
    else $error("Done flag set without a finished total.");

  a_keep_run_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_DEBUG_CTL) |=> q.keep_run == $past(i_wdata[`ADR_BIT_KEEP_RUN]))
    else $error("Keep-running bit write not taken.");

  a_keep_run_sample: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (q.keep_run && i_smp_vld) |-> lnk.smp_vld)
    else $error("Sample dropped while keep-running set.");

  a_start_one_cycle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    q.start |=> !q.start)
    else $error("Start pulse longer than one cycle.");

  a_mode_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `ADR_OFF_WIN_MODE) |=> q.mode == $past(i_wdata[2:0]))
    else $error("Compare select write not taken.");

  a_mode_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_WIN_MODE) |=> o_rdata == {5'h00, $past(q.mode)})
    else $error("Compare select read back wrong.");

  a_debug_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_DEBUG_CTL) |=> o_rdata == {7'h00, $past(q.keep_run)})
    else $error("Debug control read back wrong.");

  a_acc_sel_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_ACC_SEL) |=> o_rdata == {5'h00, $past(q.acc_sel)})
    else $error("Accumulation select read back wrong.");

  a_flags_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADR_OFF_FLAGS) |=> o_rdata == {6'h00, $past(q.whit), $past(q.done)})
    else $error("Flags read back wrong.");

  a_rdata_idle_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("Read data not zero outside a read.");
endmodule

// [hw/adr_window.sv]
// Window comparator applied to each finished total.
`timescale 1ns/10ps
`include "adr_regs.svh"
module adr_window (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Link to the core
  adr_link_if.win lnk
);
  import adr_pkg::*;

  adr_win_st_t q;
  adr_win_st_t d;
  logic below;
  logic above;

  // ============================================================
  // Unsigned comparison, only when a total is finished.
  always_comb begin
    d = q;
    below = lnk.tot < lnk.floor_v;
    above = lnk.tot > lnk.ceil_v;
    d.hit = 1'b0;
    if (lnk.tot_vld) begin
      case (lnk.mode)
        ADR_WM_BELOW: d.hit = below;
        ADR_WM_ABOVE: d.hit = above;
        ADR_WM_INSIDE: d.hit = (lnk.tot > lnk.floor_v) && (lnk.tot < lnk.ceil_v);
        ADR_WM_OUTSIDE: d.hit = below || above;
        default: d.hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.hit = q.hit;

  a_total_only: assert property (@(posedge i_ref_clk) disable iff (i_rst) !lnk.tot_vld |=> !q.hit)
    else $error("Window hit without a finished total.");
  a_below_hit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (lnk.tot_vld && lnk.mode == ADR_WM_BELOW && lnk.tot < lnk.floor_v) |=> q.hit)
    else $error("Below-floor total missed.");
  a_mode_none: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (lnk.mode == ADR_WM_NONE || lnk.mode > ADR_WM_OUTSIDE) |=> !q.hit)
    else $error("Hit reported while comparison disabled.");
endmodule
